// >>> core/fsr_map.svh
// Purpose: Offsets, fields, reset values and counts of the
//          floppy status and rate register bank.
// Assumes: 250 MHz system clock.
// Notes:   Definitions only.
//
// What this block does
// - Bits 1..0 pick tape drive 1-3, none.
// - Enhanced bits 3..2 swap drive 0 pins.
// - Four-drive configuration disables any drive exchange.
// - Drive 3 never swaps with drive 2.
// - Enhanced bits 5..4 show selected drive 0/1 ID.
// - Enhanced bits 7..6 mirror media sense pins.
// - Compatible mode floats bits 7..2, drives 1..0 with tape select.
// - Enhanced reset: bits 5..4 one, 3..0 zero.
// - Status reads anytime, no delay; a read ends power down.
// - Status reads 00h until initialisation completes.
// - Ready reports 80h within 2.5 ms.
// - Busy bit set by seek, cleared sense.
// - Command bit spans first byte to end.
// - Bit 5 flags non-DMA execution phase.
// - Bit 6 gives expected data direction.
// - Ready bit clears per byte, sets again.
// - Non-DMA execution: ready bit follows interrupt.
// - Rate comes from last rate/config write.
// - Hardware reset loads 02h; soft reset keeps.
// - Rate codes 500, 300, 250 Kbps, 1 Mbps.
// - Config bit 6 picks compatible or enhanced.
// - Power down ends on reset, status read or data byte.
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH
`define FSR_OFS_DTM      3'h3
`define FSR_OFS_STAT     3'h4
`define FSR_OFS_CCR      3'h7
`define FSR_DSR_RST      8'h02
`define FSR_DSR_PD_BIT   6
`define FSR_DSR_SR_BIT   7
`define FSR_STAT_READY   8'h80
`define FSR_ID_RST       2'h3
`define FSR_CLK_MHZ      250
`define FSR_SRST_NS      100
`define FSR_SRST_CYC     ((`FSR_SRST_NS*`FSR_CLK_MHZ+999)/1000)
`define FSR_INIT_NS      2000
`define FSR_INIT_CYC     ((`FSR_INIT_NS*`FSR_CLK_MHZ+999)/1000)
`define FSR_RQM_MAX_US   2500
`define FSR_RQM_MAX_CYC  (`FSR_RQM_MAX_US*`FSR_CLK_MHZ)
`endif

// >>> core/fsr_pkg.sv
// Purpose: Types of the floppy status and rate register bank.
// Assumes: Constants live in fsr_map.svh.
// Notes:   No imports; use fsr_pkg::name.
package fsr_pkg;
  // Controller readiness states
  typedef enum logic [1:0]
  {
    ST_INIT  = 2'b00,
    ST_READY = 2'b01,
    ST_PDOWN = 2'b10
  } fsr_state_t;
  // Logical drive exchange codes
  typedef enum logic [1:0]
  {
    XCH_NONE = 2'b00,
    XCH_01   = 2'b01,
    XCH_02   = 2'b10,
    XCH_RSVD = 2'b11
  } fsr_xchg_t;
endpackage

// >>> core/fsr_regs.sv
// Purpose: Drive type/media, controller status and rate select
//          registers of a floppy controller.
// Assumes: Sequencer events are one-cycle pulses on SYS_CLK_I.
// Notes:   Read data stand one cycle after the read strobe.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_regs
#(
  parameter int INIT_CYC    = `FSR_INIT_CYC,
  parameter int RQM_MAX_CYC = `FSR_RQM_MAX_CYC
)
(
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic [2:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  output logic      [7:0] RDATA_OE_O,
  input  wire logic       CFG_FOUR_DRIVE_I,
  input  wire logic       CFG_ENH_MODE_I,
  input  wire logic [3:0] DRIVE_ID_I,
  input  wire logic [1:0] DRV_SEL_I,
  input  wire logic       MEDIA_SENSE_LO_I,
  input  wire logic       MEDIA_SENSE_HI_I,
  input  wire logic       SOFT_RST_I,
  input  wire logic       CMD_FIRST_WR_I,
  input  wire logic       CMD_END_I,
  input  wire logic [3:0] SEEK_ISSUED_I,
  input  wire logic [3:0] SENSE_READ_I,
  input  wire logic       EXEC_NDMA_I,
  input  wire logic       DIR_READ_I,
  input  wire logic       DATA_XFER_I,
  input  wire logic       BYTE_READY_I,
  input  wire logic       IRQ_I,
  output logic      [1:0] TAPE_SEL_O,
  output logic            SWAP_01_O,
  output logic            SWAP_02_O,
  output logic      [1:0] DATA_RATE_O,
  output logic      [2:0] PRECOMP_O,
  output logic            POWER_DOWN_O,
  output logic            SW_RESET_O
);

  // Decoded bus strobes
  logic              wr_dtm;      // Drive type/media write
  logic              wr_dsr;      // Rate select write
  logic              wr_ccr;      // Config control rate write
  logic              rd_stat;     // Status read
  logic              rd_dtm;      // Drive type/media read
  // Register state
  logic [1:0]        tape_r;      // Tape drive select
  logic [1:0]        xchg_r;      // Exchange field
  logic              id_rst_r;    // ID field still at reset value
  logic [7:0]        dsr_r;       // Rate select register
  logic [1:0]        rate_r;      // Active data rate
  logic              swap01_r;    // Effective 0/1 exchange
  logic              swap02_r;    // Effective 0/2 exchange
  // Status state
  fsr_pkg::fsr_state_t st_r;      // Readiness state
  logic [15:0]       init_cnt_r;  // Clock settle counter
  logic [3:0]        busy_r;      // Per-drive busy
  logic              cip_r;       // Command in progress
  logic              rqm_r;       // Ready for next byte
  logic [4:0]        srst_cnt_r;  // Self-clearing reset timer
  logic              srst;        // Any soft reset this cycle
  logic              wake;        // Power-down exit event
  logic [7:0]        stat_val;    // Status byte as read
  logic              rqm_eff;     // Ready bit as seen
  logic [1:0]        id_val;      // Drive ID field
  // Media sense synchronisers
  logic [1:0]        ms_meta_r;   // First stage, read by second only
  logic [1:0]        ms_r;        // Second stage {hi, lo}
  // Read path
  logic [7:0]        rdata_nxt;
  logic [7:0]        oe_nxt;

  // Address decode; offset 4 splits by direction
  assign wr_dtm  = WR_I && (ADDR_I == `FSR_OFS_DTM);
  assign wr_dsr  = WR_I && (ADDR_I == `FSR_OFS_STAT);
  assign wr_ccr  = WR_I && (ADDR_I == `FSR_OFS_CCR);
  assign rd_stat = RD_I && (ADDR_I == `FSR_OFS_STAT);
  assign rd_dtm  = RD_I && (ADDR_I == `FSR_OFS_DTM);

  // Both soft reset sources act alike
  assign srst = SOFT_RST_I || (srst_cnt_r != 5'h00);
  // Any data or status access ends a manual power down
  assign wake = srst || DATA_XFER_I || rd_stat;

  // Media sense pins come from outside the clock domain
  always_ff @(posedge SYS_CLK_I)
  begin
    ms_meta_r <= {MEDIA_SENSE_HI_I, MEDIA_SENSE_LO_I};
    ms_r      <= ms_meta_r;
  end

  // Drive type/media register
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      tape_r   <= 2'h0;
      xchg_r   <= 2'h0;
      id_rst_r <= 1'b1;
    end
    else if (wr_dtm)
    begin
      tape_r   <= WDATA_I[1:0];
      id_rst_r <= 1'b0;
      // Exchange bits exist only in enhanced mode
      if (CFG_ENH_MODE_I)
      begin
        xchg_r <= WDATA_I[3:2];
      end
    end
  end

  // Effective exchange; reserved code swaps nothing, and drive 3
  // has no exchange path at all
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      swap01_r <= 1'b0;
      swap02_r <= 1'b0;
    end
    else
    begin
      swap01_r <= CFG_ENH_MODE_I && !CFG_FOUR_DRIVE_I &&
                  (xchg_r == fsr_pkg::XCH_01);
      swap02_r <= CFG_ENH_MODE_I && !CFG_FOUR_DRIVE_I &&
                  (xchg_r == fsr_pkg::XCH_02);
    end
  end

  // Rate select register; soft reset leaves it alone
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      dsr_r <= `FSR_DSR_RST;
    end
    else if (wr_dsr)
    begin
      dsr_r <= WDATA_I;
    end
  end

  // Active rate follows whichever rate register was written last
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      rate_r <= 2'(`FSR_DSR_RST);
    end
    else if (wr_dsr || wr_ccr)
    begin
      rate_r <= WDATA_I[1:0];
    end
  end

  // Self-clearing soft reset from the rate register
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      srst_cnt_r <= 5'h00;
    end
    else if (wr_dsr && WDATA_I[`FSR_DSR_SR_BIT])
    begin
      srst_cnt_r <= 5'(`FSR_SRST_CYC);
    end
    else if (srst_cnt_r != 5'h00)
    begin
      srst_cnt_r <= srst_cnt_r - 5'h01;
    end
  end

  // Readiness: settle after reset or wake, then serve commands
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      st_r       <= fsr_pkg::ST_INIT;
      init_cnt_r <= 16'h0000;
    end
    else
    begin
      case (st_r)
        fsr_pkg::ST_INIT:
        begin
          // Reset during settling restarts the wait
          if (srst)
          begin
            init_cnt_r <= 16'h0000;
          end
          else if (init_cnt_r >= 16'(INIT_CYC - 1))
          begin
            st_r <= fsr_pkg::ST_READY;
          end
          else
          begin
            init_cnt_r <= init_cnt_r + 16'h0001;
          end
        end
        fsr_pkg::ST_READY:
        begin
          init_cnt_r <= 16'h0000;
          if (srst)
          begin
            st_r <= fsr_pkg::ST_INIT;
          end
          else if (wr_dsr && WDATA_I[`FSR_DSR_PD_BIT])
          begin
            st_r <= fsr_pkg::ST_PDOWN;
          end
        end
        fsr_pkg::ST_PDOWN:
        begin
          // Clock must restabilise before status is valid
          if (wake)
          begin
            st_r <= fsr_pkg::ST_INIT;
          end
        end
        default:
        begin
          st_r <= fsr_pkg::ST_INIT;
        end
      endcase
    end
  end

  // Per-drive busy; a set in the clearing cycle wins
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I || srst)
    begin
      busy_r <= 4'h0;
    end
    else
    begin
      busy_r <= (busy_r & ~SENSE_READ_I) | SEEK_ISSUED_I;
    end
  end

  // Command in progress; first byte wins over an end event
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I || srst)
    begin
      cip_r <= 1'b0;
    end
    else if (CMD_FIRST_WR_I)
    begin
      cip_r <= 1'b1;
    end
    else if (CMD_END_I)
    begin
      cip_r <= 1'b0;
    end
  end

  // Byte handshake; ready again wins over a finished transfer
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I || srst || (st_r != fsr_pkg::ST_READY))
    begin
      rqm_r <= 1'b0;
    end
    else if (BYTE_READY_I || (init_cnt_r != 16'h0000))
    begin
      rqm_r <= 1'b1;
    end
    else if (DATA_XFER_I)
    begin
      rqm_r <= 1'b0;
    end
  end

  // Status byte; zero until settled, interrupt drives bit 7 in
  // non-DMA execution
  assign rqm_eff  = EXEC_NDMA_I ? IRQ_I : rqm_r;
  assign stat_val = (st_r == fsr_pkg::ST_READY) ?
                    {rqm_eff, DIR_READ_I, EXEC_NDMA_I,
                     cip_r, busy_r} : 8'h00;

  // Drive ID source by selected drive
  always_comb
  begin
    if (id_rst_r)
    begin
      id_val = `FSR_ID_RST;
    end
    else
    begin
      case (DRV_SEL_I)
        2'h0:    id_val = DRIVE_ID_I[1:0];
        2'h1:    id_val = DRIVE_ID_I[3:2];
        default: id_val = 2'h0;
      endcase
    end
  end

  // Read mux; unmapped reads return zero, driven
  always_comb
  begin
    rdata_nxt = 8'h00;
    oe_nxt    = 8'h00;
    if (rd_stat)
    begin
      // Pure read: no state changes here
      rdata_nxt = stat_val;
      oe_nxt    = 8'hff;
    end
    else if (rd_dtm && CFG_ENH_MODE_I)
    begin
      rdata_nxt = {ms_r, id_val, xchg_r, tape_r};
      oe_nxt    = 8'hff;
    end
    else if (rd_dtm)
    begin
      rdata_nxt = {6'h00, tape_r};
      oe_nxt    = 8'h03;
    end
    else if (RD_I)
    begin
      oe_nxt = 8'hff;
    end
  end

  // Read data register, valid only the cycle after the strobe
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      RDATA_O    <= 8'h00;
      RDATA_OE_O <= 8'h00;
    end
    else
    begin
      RDATA_O    <= rdata_nxt;
      RDATA_OE_O <= oe_nxt;
    end
  end

  // Control outputs registered
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      POWER_DOWN_O <= 1'b0;
      SW_RESET_O   <= 1'b0;
    end
    else
    begin
      POWER_DOWN_O <= (st_r == fsr_pkg::ST_PDOWN);
      SW_RESET_O   <= srst;
    end
  end

  assign TAPE_SEL_O  = tape_r;
  assign SWAP_01_O   = swap01_r;
  assign SWAP_02_O   = swap02_r;
  assign DATA_RATE_O = rate_r;
  assign PRECOMP_O   = dsr_r[4:2];

  // Helper: cycles spent settling in ST_INIT since the last reset or ready
  logic [19:0] wait_cnt_r;
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I || srst || (st_r == fsr_pkg::ST_READY))
    begin
      wait_cnt_r <= 20'h00000;
    end
    else if (st_r == fsr_pkg::ST_INIT)
    begin
      wait_cnt_r <= wait_cnt_r + 20'h00001;
    end
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_rst_rel;
    !$past(RST_N_I);
  endsequence
  sequence s_srst_req;
    wr_dsr && WDATA_I[`FSR_DSR_SR_BIT];
  endsequence

  property p_stat_zero;
    rd_stat && (st_r != fsr_pkg::ST_READY) |=> RDATA_O == 8'h00;
  endproperty
  a_stat_zero: assert property (p_stat_zero)
    else $error("status not zero before ready");

  property p_ready_bound;
    wait_cnt_r < 20'(RQM_MAX_CYC);
  endproperty
  a_ready_bound: assert property (p_ready_bound)
    else $error("ready not reached in time");

  property p_dsr_reset;
    s_rst_rel |-> dsr_r == `FSR_DSR_RST &&
                  DATA_RATE_O == 2'(`FSR_DSR_RST);
  endproperty
  a_dsr_reset: assert property (p_dsr_reset)
    else $error("rate select reset value wrong");

  property p_rate_last;
    (wr_dsr || wr_ccr) |=> DATA_RATE_O == $past(WDATA_I[1:0]);
  endproperty
  a_rate_last: assert property (p_rate_last)
    else $error("rate not from last write");

  property p_busy_set;
    SEEK_ISSUED_I[0] && !srst |=> busy_r[0];
  endproperty
  a_busy_set: assert property (p_busy_set)
    else $error("drive busy not set");

  property p_four_noswap;
    CFG_FOUR_DRIVE_I && $past(CFG_FOUR_DRIVE_I) |->
      !SWAP_01_O && !SWAP_02_O;
  endproperty
  a_four_noswap: assert property (p_four_noswap)
    else $error("exchange active with four drives");

  property p_compat_float;
    rd_dtm && !CFG_ENH_MODE_I |=>
      RDATA_OE_O == 8'h03 && RDATA_O[1:0] == $past(tape_r);
  endproperty
  a_compat_float: assert property (p_compat_float)
    else $error("compatible read drives upper bits");

  property p_srst_pulse;
    // The pin is a registered copy of the internal reset, so it
    // rises one cycle after the counter is loaded
    s_srst_req |=> ##1 SW_RESET_O [*8];
  endproperty
  a_srst_pulse: assert property (p_srst_pulse)
    else $error("soft reset pulse too short");

  property p_irq_mirror;
    rd_stat && EXEC_NDMA_I && (st_r == fsr_pkg::ST_READY) |=>
      RDATA_O[7] == $past(IRQ_I) && RDATA_O[5];
  endproperty
  a_irq_mirror: assert property (p_irq_mirror)
    else $error("ready bit not following interrupt");

  property p_id_hi;
    rd_dtm && CFG_ENH_MODE_I && !id_rst_r && DRV_SEL_I[1] |=>
      RDATA_O[5:4] == 2'h0;
  endproperty
  a_id_hi: assert property (p_id_hi)
    else $error("drive ID not zero for drives 2/3");

endmodule

// >>> sim/fsr_host.sv
// Purpose: Host processor model on the register port.
// Assumes: One-cycle strobes; read data stand one cycle later.
// Notes:   Bus signals change only just after a rising edge.
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_host
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic [7:0] rdata_oe_i,
  output logic      [2:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  // Idle bus from time zero
  initial
  begin
    addr_o  = 3'h0;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  // One write cycle; data flips afterwards so nothing leans on it
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask
  // One read cycle; data taken in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d,
                    output logic [7:0] oe);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d  = rdata_i;
    oe = rdata_oe_i;
  endtask
  // Status look before a data byte moves
  task automatic poll(output logic [7:0] d);
    logic [7:0] oe;
    rd(`FSR_OFS_STAT, d, oe);
  endtask
endmodule

// >>> sim/test_floppy_status_rate_registers.sv
// Purpose: Self-checking bench of the floppy status and rate registers.
// Assumes: Short settling counts; the bench plays the sequencer.
// Notes:   An integer model predicts every rate result and the settled status.
`timescale 1ns/1ps
`include "fsr_map.svh"
module test_floppy_status_rate_registers;
  localparam int INIT = 4;    // Short settling keeps the run brief
  localparam int RQMX = 1000; // Ready deadline in cycles
  logic       clk, rst_n, four, enh, ms_lo, ms_hi, srst;
  logic       cfirst, cend, exec, dir, xfer, bready, irq;
  logic [3:0] id, seek, sense;
  logic [1:0] sel, tape, rate;
  logic [2:0] addr, prec;
  logic [7:0] wdata, rdata, oe;
  logic       wr, rd, sw01, sw02, pd, swr;
  int         n_mismatch, total_checks;
  int         m_busy, m_cip, m_rqm, m_prec; // Status and precomp model
  int         rate_q[$];                    // Rate writes, newest last

  fsr_host host
  (
    .clk_i      (clk),
    .rdata_i    (rdata),
    .rdata_oe_i (oe),
    .addr_o     (addr),
    .wdata_o    (wdata),
    .wr_o       (wr),
    .rd_o       (rd)
  );

  fsr_regs #(.INIT_CYC(INIT), .RQM_MAX_CYC(RQMX)) uut
  (
    .SYS_CLK_I        (clk),
    .RST_N_I          (rst_n),
    .ADDR_I           (addr),
    .WDATA_I          (wdata),
    .WR_I             (wr),
    .RD_I             (rd),
    .RDATA_O          (rdata),
    .RDATA_OE_O       (oe),
    .CFG_FOUR_DRIVE_I (four),
    .CFG_ENH_MODE_I   (enh),
    .DRIVE_ID_I       (id),
    .DRV_SEL_I        (sel),
    .MEDIA_SENSE_LO_I (ms_lo),
    .MEDIA_SENSE_HI_I (ms_hi),
    .SOFT_RST_I       (srst),
    .CMD_FIRST_WR_I   (cfirst),
    .CMD_END_I        (cend),
    .SEEK_ISSUED_I    (seek),
    .SENSE_READ_I     (sense),
    .EXEC_NDMA_I      (exec),
    .DIR_READ_I       (dir),
    .DATA_XFER_I      (xfer),
    .BYTE_READY_I     (bready),
    .IRQ_I            (irq),
    .TAPE_SEL_O       (tape),
    .SWAP_01_O        (sw01),
    .SWAP_02_O        (sw02),
    .DATA_RATE_O      (rate),
    .PRECOMP_O        (prec),
    .POWER_DOWN_O     (pd),
    .SW_RESET_O       (swr)
  );

  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Register read compare
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: read %h not %h", $time, got, exp);
    end
  endtask

  // Output pin compare
  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: pin %h not %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] e,
                       input logic [7:0] eo);
    logic [7:0] d, o;
    host.rd(a, d, o);
    chk_rd(d, e);
    chk_rd(o, eo);
  endtask

  // Status the model predicts; in non-DMA execution bit 7 is the irq
  function automatic logic [7:0] exp_st();
    int r;
    r = m_busy + 16 * m_cip + 32 * int'(exec) + 64 * int'(dir);
    r += 128 * (exec ? int'(irq) : m_rqm);
    return r[7:0];
  endfunction

  // One-cycle sequencer event: 0 seek, 1 sense, 2 first, 3 end,
  // 4 data byte, 5 byte ready, other soft reset
  task automatic ev(input int k, input logic [3:0] m);
    @(posedge clk);
    case (k)
      0: seek <= m;
      1: sense <= m;
      2: cfirst <= 1'b1;
      3: cend <= 1'b1;
      4: xfer <= 1'b1;
      5: bready <= 1'b1;
      default: srst <= 1'b1;
    endcase
    @(posedge clk);
    {seek, sense, cfirst, cend, xfer, bready, srst} <= '0;
  endtask

  // Execution, direction and irq levels, settled one cycle
  task automatic lvl(input logic [2:0] v);
    @(posedge clk);
    {exec, dir, irq} <= v;
    @(posedge clk);
  endtask

  task automatic chk_rate;
    @(posedge clk);
    #1;
    chk_pin({2'h0, rate}, 4'(rate_q[$]));
    chk_pin({1'h0, prec}, 4'(m_prec));
  endtask

  task automatic hard_reset;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rate_q.delete();
    rate_q.push_back(2);
    m_prec = 0;
    m_busy = 0;
    m_cip  = 0;
  endtask

  // Bounded poll; running out counts as a mismatch and ends the run
  task automatic wait_ready;
    logic [7:0] d;
    int         n;
    n = 0;
    do
    begin
      host.poll(d);
      n++;
    end
    while (d !== 8'h80 && n < RQMX / 2);
    chk_rd(d, 8'h80);
    m_rqm = 1;
    if (d !== 8'h80)
      final_report();
  endtask

  task automatic done(input string s);
    $display("%s done", s);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    logic [7:0] d, w;
    logic [2:0] p;
    logic [1:0] f;
    {rst_n, four, ms_lo, ms_hi, srst, cfirst, cend, exec, dir} = '0;
    {xfer, bready, irq, id, seek, sense, sel} = '0;
    enh = 1'b1;
    n_mismatch = 0;
    total_checks = 0;
    void'($urandom(32'hdbc48da0));
    hard_reset();
    host.poll(d);
    chk_rd(d, 8'h00);
    chk_rate();
    chk_pin({tape, sw01, sw02}, 4'h0);
    chk_pin({2'h0, pd, swr}, 4'h0);
    rdchk(`FSR_OFS_DTM, 8'h30, 8'hff);
    wait_ready();
    done("reset");
    // Busy bits pile up, then clear one drive at a time
    for (int k = 0; k < 8; k++)
    begin
      ev(k / 4, 4'h1 << (k % 4));
      m_busy += (k < 4) ? (1 << k) : -(1 << (k - 4));
      rdchk(`FSR_OFS_STAT, exp_st(), 8'hff);
      rdchk(`FSR_OFS_STAT, exp_st(), 8'hff);
    end
    for (int k = 2; k < 6; k++)
    begin
      ev(k, 4'h0);
      m_cip = (k == 2) ? 1 : (k == 3) ? 0 : m_cip;
      m_rqm = (k == 4) ? 0 : 1;
      rdchk(`FSR_OFS_STAT, exp_st(), 8'hff);
    end
    lvl(3'h2);
    rdchk(`FSR_OFS_STAT, exp_st(), 8'hff);
    lvl(3'h4);
    rdchk(`FSR_OFS_STAT, exp_st(), 8'hff);
    lvl(3'h5);
    rdchk(`FSR_OFS_STAT, exp_st(), 8'hff);
    lvl(3'h0);
    done("status");
    for (int i = 0; i < 16; i++)
    begin
      w = 8'($urandom);
      w[3:2] = i[1:0];
      @(posedge clk);
      {four, sel} <= {i[3], i[3:2]};
      {id, ms_lo, ms_hi} <= 6'($urandom);
      host.wr(`FSR_OFS_DTM, w);
      repeat (3) @(posedge clk);
      #1;
      f = (sel == 2'h0) ? id[1:0] : (sel == 2'h1) ? id[3:2] : 2'h0;
      chk_pin({2'h0, tape}, {2'h0, w[1:0]});
      chk_pin({2'h0, sw01, sw02},
              {2'h0, i[1:0] == 2'h1 && !four,
               i[1:0] == 2'h2 && !four});
      rdchk(`FSR_OFS_DTM, {ms_hi, ms_lo, f, w[3:0]}, 8'hff);
    end
    @(posedge clk);
    four <= 1'b0;
    host.wr(`FSR_OFS_DTM, 8'h00);
    enh <= 1'b0;
    host.wr(`FSR_OFS_DTM, 8'hff);
    rdchk(`FSR_OFS_DTM, 8'h03, 8'h03);
    chk_pin({2'h0, sw01, sw02}, 4'h0);
    @(posedge clk);
    enh <= 1'b1;
    rdchk(`FSR_OFS_DTM, {ms_hi, ms_lo, 6'h03}, 8'hff);
    done("drive type");
    for (int r = 0; r < 4; r++)
    begin
      p = 3'($urandom);
      w = 8'($urandom);
      host.wr(`FSR_OFS_STAT, {3'h0, p, r[1:0]});
      rate_q.push_back(r);
      m_prec = p;
      chk_rate();
      host.wr(`FSR_OFS_CCR, w);
      rate_q.push_back(w[1:0]);
      chk_rate();
    end
    done("rate");
    ev(0, 4'h4);
    host.wr(`FSR_OFS_STAT, 8'h95);
    rate_q.push_back(1);
    m_prec = 5;
    m_busy = 0;
    repeat (2) @(posedge clk);
    #1;
    chk_pin({3'h0, swr}, 4'h1);
    host.poll(d);
    chk_rd(d, 8'h00);
    wait_ready();
    chk_rate();
    ev(6, 4'h0);
    host.poll(d);
    chk_rd(d, 8'h00);
    wait_ready();
    chk_rate();
    done("soft reset");
    host.wr(`FSR_OFS_STAT, 8'h55);
    @(posedge clk);
    #1;
    chk_pin({3'h0, pd}, 4'h1);
    host.poll(d);
    chk_rd(d, 8'h00);
    wait_ready();
    chk_pin({3'h0, pd}, 4'h0);
    // A data byte moving also ends a power down
    host.wr(`FSR_OFS_STAT, 8'h55);
    ev(4, 4'h0);
    host.poll(d);
    chk_rd(d, 8'h00);
    wait_ready();
    // Unmapped read returns zero, driven
    rdchk(3'h7, 8'h00, 8'hff);
    done("power down");
    @(posedge clk);
    enh <= 1'b0;
    hard_reset();
    chk_rate();
    rdchk(`FSR_OFS_DTM, 8'h00, 8'h03);
    done("hard reset");
    final_report();
  end
endmodule
